// ==== hw/pmd_dispatch.sv ====
// Request dispatch and pattern RAM sequencing for the programmable memory machines.
//
// Function
// [R01] Normal opcode reads start at word 0x00 single or 0x08 burst.
// [R02] Normal opcode writes start at word 0x18 single or 0x20 burst.
// [R03] Refresh timer expiry launches the refresh pattern at word 0x30.
// [R04] Bus monitor time-out in a running pattern branches to word 0x3C.
// [R05] Run opcode writes start a pattern at the word pointer.
// [R06] Software patterns step through words until the end bit is set.
// [R07] Software patterns ignore acknowledges; bus driven only during address latch phases.
// [R08] Single-beat transfer: one start, exactly one acknowledge.
// [R09] Burst moves four double words: eight acks on 32-bit, 32 on 8-bit.
// [R10] Programmer places exactly the needed acknowledge bits in each pattern.
// [R11] Transfers not fitting single or burst become back-to-back singles; the code runs one single-beat pattern per such request instead.
// [R12] Burst-inhibited banks get single-beat transfers only.
// [R13] One shared refresh period drives all three machines' refresh timers.
// [R14] Refresh always runs machine A pattern; B and C join when enabled.
// [R15] Shared refresh asserts chip selects of every refresh-enabled machine.
// [R16] Write opcode dummy write stores pattern data into the pointed word.
// [R17] Read opcode dummy read loads the pointed word into pattern data.
// [R18] Word pointer increments when a dummy access completes.
// [R19] Software leaves mode and data alone during a dummy access.
// [R20] Software sets banks, RAM, refresh, then mode register, in order.
// [R21] Last acknowledge and end bit share a word, or adjacent for reads.
// [R22] Each machine's pattern RAM holds 64 words of 32 bits.
// [R23] Two idle local bus clock cycles separate machine transactions.
// [R24] New requests wait for the running pattern except time-outs.
`timescale 1ns/10ps
module pmd_dispatch (
    // Clock and reset.
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // Local bus clock pin, sampled by mclk.
    input  wire logic                      local_bus_clock,
    // Internal access requests.
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire pmd_pkg::pmd_req_t         req,
    // Mode configuration per machine.
    input  wire pmd_pkg::pmd_mode_t        mode_a,
    input  wire pmd_pkg::pmd_mode_t        mode_b,
    input  wire pmd_pkg::pmd_mode_t        mode_c,
    input  wire logic                      port_8bit,
    input  wire logic [2:0]                burst_inhibit,
    // Shared refresh period in local bus clocks.
    input  wire logic [7:0]                refresh_period_reg,
    // Bus monitor time-out pulse.
    input  wire logic                      bus_timeout,
    // Software writes of the pattern data register.
    input  wire logic                      pdr_wr,
    input  wire logic [31:0]               pdr_wdata,
    output logic      [31:0]               pattern_data_reg,
    // Live word pointers, which software polls.
    output logic      [5:0]                ptr_a,
    output logic      [5:0]                ptr_b,
    output logic      [5:0]                ptr_c,
    // Pattern execution status and outputs.
    output logic                           busy,
    output logic      [31:0]               ram_word,
    output logic                           ram_word_valid,
    output logic      [2:0]                chip_sel,
    output logic                           xfer_start,
    output logic                           xfer_ack,
    output logic                           address_latch_enable,
    output logic                           muxed_bus_oe
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_GAP
    } pmd_state_t;

    typedef enum logic [1:0] {
        K_NORMAL,
        K_REFRESH,
        K_SOFT
    } pmd_kind_t;

    // Start word chooser for normal requests.
    function automatic logic [5:0] start_word(input logic wr, input logic bst);
        if (wr) begin
            return bst ? pmd_pkg::BURST_WRITE_PATTERN : pmd_pkg::SINGLE_WRITE_PATTERN;
        end
        return bst ? pmd_pkg::BURST_READ_PATTERN : pmd_pkg::SINGLE_READ_PATTERN;
    endfunction : start_word

    // Selects one machine's mode by index.
    function automatic pmd_pkg::pmd_mode_t pick_mode(input logic [1:0] m,
                                                     input pmd_pkg::pmd_mode_t a,
                                                     input pmd_pkg::pmd_mode_t b,
                                                     input pmd_pkg::pmd_mode_t c);
        case (m)
            2'h1:    return b;
            2'h2:    return c;
            default: return a;
        endcase
    endfunction : pick_mode

    // [R22] Pattern RAM storage.
    logic [31:0]          ram_q [pmd_pkg::N_MACH][pmd_pkg::RAM_DEPTH];
    pmd_state_t           state_q;
    pmd_kind_t            kind_q;
    logic [1:0]           mach_q;
    logic [5:0]           pc_q;
    logic [5:0]           acks_q;
    logic [5:0]           acks_need_q;
    logic [1:0]           gap_q;
    logic [1:0]           amx_q;
    logic                 first_q;
    logic [2:0]           cs_q;
    logic [5:0]           ptr_q [pmd_pkg::N_MACH];
    logic [1:0]           ptr_base_op_q [pmd_pkg::N_MACH];
    logic [31:0]          pdr_q;
    logic [7:0]           rtimer_q;
    logic                 rpend_q;
    logic                 local_bus_clock_rise;
    logic                 q_valid;
    logic                 q_ready;
    pmd_pkg::pmd_req_t    q_req;
    pmd_pkg::pmd_mode_t   q_mode;
    logic [31:0]          cur_word;
    logic                 launch;
    logic                 end_of_pattern;

    // Local bus clock edges are found after two synchroniser flops.
    pmd_sync u_local_bus_clock (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (local_bus_clock),
        .sync_out (),
        .rise     (local_bus_clock_rise)
    );

    // Requests queue here; req_ready drops only when all 16 FIFO entries are held.
    pmd_fifo #(
        .WIDTH (pmd_pkg::REQ_W),
        .DEPTH (pmd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (req),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_req)
    );

    assign q_mode   = pick_mode(q_req.machine, mode_a, mode_b, mode_c);
    assign cur_word = ram_q[mach_q][pc_q];
    assign end_of_pattern = cur_word[pmd_pkg::BIT_LAST];

    // [R24] Head request launches only from idle on a bus clock edge.
    assign launch  = (state_q == ST_IDLE) && local_bus_clock_rise && q_valid && !rpend_q;
    // Dummy accesses finish in one step, so they pop at launch like normal ones.
    assign q_ready = launch;

    // [R13] Shared refresh timer counts bus clocks for all machines.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rtimer_q <= 8'h00;
            rpend_q  <= 1'b0;
        end else begin
            if (local_bus_clock_rise) begin
                if (rtimer_q >= refresh_period_reg) begin
                    rtimer_q <= 8'h00;
                end else begin
                    rtimer_q <= 8'(rtimer_q + 1'b1);
                end
            end
            // The expiry wins over the clear so no refresh is lost.
            // [R14] Machine A's enable alone raises a refresh.
            if (local_bus_clock_rise && rtimer_q >= refresh_period_reg && refresh_period_reg != 8'h00 &&
                mode_a.refresh_enable) begin
                rpend_q <= 1'b1;
            end else if (state_q == ST_IDLE && local_bus_clock_rise) begin
                rpend_q <= 1'b0;
            end
        end
    end

    // Main sequencer: choose pattern, step words, then hold the idle gap.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            kind_q      <= K_NORMAL;
            mach_q      <= 2'h0;
            pc_q        <= 6'h00;
            acks_q      <= 6'h00;
            acks_need_q <= 6'h00;
            gap_q       <= 2'h0;
            cs_q        <= 3'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (local_bus_clock_rise && rpend_q) begin
                        // [R03] Refresh runs from machine A's refresh word.
                        state_q <= ST_RUN;
                        kind_q  <= K_REFRESH;
                        mach_q  <= 2'(pmd_pkg::MACH_A);
                        pc_q    <= pmd_pkg::REFRESH_PATTERN;
                        // [R15] Every refresh-enabled machine's select joins in.
                        cs_q    <= {mode_c.refresh_enable, mode_b.refresh_enable, 1'b1};
                    end else if (launch && q_mode.machine_opcode == pmd_pkg::OP_NORMAL) begin
                        state_q <= ST_RUN;
                        kind_q  <= K_NORMAL;
                        mach_q  <= q_req.machine;
                        // [R01] [R02] Start word by direction and shape.
                        // [R11] [R12] Odd shapes and inhibited banks fall back to single beats.
                        pc_q    <= start_word(q_req.write, q_req.burst && q_req.fits &&
                                              !burst_inhibit[q_req.machine]);
                        // [R08] [R09] Acknowledge budget of the transfer.
                        if (q_req.burst && q_req.fits && !burst_inhibit[q_req.machine]) begin
                            acks_need_q <= port_8bit ? pmd_pkg::BURST_ACKS_8 : pmd_pkg::BURST_ACKS_32;
                        end else begin
                            acks_need_q <= pmd_pkg::SINGLE_ACKS;
                        end
                        acks_q  <= 6'h00;
                        cs_q    <= 3'(1 << q_req.machine);
                    end else if (launch && q_mode.machine_opcode == pmd_pkg::OP_RUN && q_req.write) begin
                        // [R05] Software run starts at the word pointer.
                        state_q <= ST_RUN;
                        kind_q  <= K_SOFT;
                        mach_q  <= q_req.machine;
                        pc_q    <= q_mode.ram_word_pointer;
                        cs_q    <= 3'(1 << q_req.machine);
                    end else if (launch) begin
                        // Dummy accesses and non-write run hits still honour the gap.
                        state_q <= ST_GAP;
                        gap_q   <= 2'h0;
                    end
                end
                ST_RUN: begin
                    if (local_bus_clock_rise) begin
                        if (kind_q != K_SOFT && cur_word[pmd_pkg::BIT_XFER_ACK]) begin
                            acks_q <= 6'(acks_q + 1'b1);
                        end
                        if (bus_timeout && kind_q == K_NORMAL && cur_word[pmd_pkg::BIT_EXEN]) begin
                            // [R04] Time-out branches to the exception pattern.
                            pc_q   <= pmd_pkg::EXCEPTION_PATTERN;
                            kind_q <= K_SOFT;
                        end else if (end_of_pattern) begin
                            // [R06] The end bit closes every pattern kind.
                            state_q <= ST_GAP;
                            gap_q   <= 2'h0;
                            cs_q    <= 3'h0;
                        end else begin
                            pc_q <= 6'(pc_q + 1'b1);
                        end
                    end
                end
                ST_GAP: begin
                    // [R23] Two idle bus clocks between transactions.
                    if (local_bus_clock_rise) begin
                        gap_q <= 2'(gap_q + 1'b1);
                        if (2'(gap_q + 1'b1) == pmd_pkg::IDLE_GAP) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Address mux tracking and the first-word latch phase.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            amx_q   <= 2'h0;
            first_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            first_q <= 1'b1;
        end else if (state_q == ST_RUN && local_bus_clock_rise) begin
            first_q <= 1'b0;
            amx_q   <= cur_word[pmd_pkg::AMX_HI:pmd_pkg::AMX_LO];
        end
    end

    // [R16] Write-opcode dummy write stores pattern data; pattern RAM is not reset.
    always_ff @(posedge mclk) begin
        if (launch && q_req.write && q_mode.machine_opcode == pmd_pkg::OP_WRITE) begin
            ram_q[q_req.machine][q_mode.ram_word_pointer] <= pdr_q;
        end
    end

    // [R17] Read-opcode dummy read fetches the pointed word; software writes otherwise.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pdr_q <= 32'h0000_0000;
        end else if (launch && !q_req.write && q_mode.machine_opcode == pmd_pkg::OP_READ) begin
            pdr_q <= ram_q[q_req.machine][q_mode.ram_word_pointer];
        end else if (pdr_wr) begin
            pdr_q <= pdr_wdata;
        end
    end

    // [R18] Pointer increments on dummy completion; reloads from mode on an opcode change or an idle normal-mode pointer change.
    for (genvar m = 0; m < pmd_pkg::N_MACH; m++) begin : g_ptr
        pmd_pkg::pmd_mode_t mm;
        assign mm = pick_mode(2'(m), mode_a, mode_b, mode_c);
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                ptr_q[m] <= 6'h00;
                ptr_base_op_q[m] <= 2'h0;
            end else if (launch && q_req.machine == 2'(m) &&
                         ((q_req.write && mm.machine_opcode == pmd_pkg::OP_WRITE) ||
                          (!q_req.write && mm.machine_opcode == pmd_pkg::OP_READ))) begin
                ptr_q[m] <= 6'(mm.ram_word_pointer + 1'b1);
                ptr_base_op_q[m] <= mm.machine_opcode;
            end else if (mm.machine_opcode != ptr_base_op_q[m] || state_q == ST_IDLE && !launch &&
                         mm.ram_word_pointer != ptr_q[m] && mm.machine_opcode == pmd_pkg::OP_NORMAL) begin
                ptr_q[m] <= mm.ram_word_pointer;
                ptr_base_op_q[m] <= mm.machine_opcode;
            end
        end
    end

    // Registered outputs of the running word.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ram_word             <= 32'h0000_0000;
            ram_word_valid       <= 1'b0;
            chip_sel             <= 3'h0;
            xfer_start           <= 1'b0;
            xfer_ack             <= 1'b0;
            address_latch_enable <= 1'b0;
            muxed_bus_oe         <= 1'b0;
        end else begin
            ram_word       <= (state_q == ST_RUN) ? cur_word : 32'h0000_0000;
            ram_word_valid <= (state_q == ST_RUN) && local_bus_clock_rise;
            chip_sel       <= (state_q == ST_RUN) ? cs_q : 3'h0;
            // [R08] One transfer start per normal transaction.
            xfer_start     <= (state_q == ST_RUN) && local_bus_clock_rise && first_q && kind_q == K_NORMAL;
            // [R07] Acknowledges are suppressed for software patterns.
            // [R10] The ack budget caps what a careless pattern could signal.
            xfer_ack       <= (state_q == ST_RUN) && local_bus_clock_rise && kind_q != K_SOFT &&
                              cur_word[pmd_pkg::BIT_XFER_ACK] && acks_q < acks_need_q;
            // [R07] Latch phase on first word or on a change of the mux field.
            address_latch_enable <= (state_q == ST_RUN) && local_bus_clock_rise &&
                                    (first_q || cur_word[pmd_pkg::AMX_HI:pmd_pkg::AMX_LO] != amx_q);
            muxed_bus_oe   <= (state_q == ST_RUN) && local_bus_clock_rise &&
                              (first_q || cur_word[pmd_pkg::AMX_HI:pmd_pkg::AMX_LO] != amx_q);
        end
    end

    assign busy             = (state_q != ST_IDLE);
    assign pattern_data_reg = pdr_q;
    assign ptr_a            = ptr_q[0];
    assign ptr_b            = ptr_q[1];
    assign ptr_c            = ptr_q[2];
endmodule : pmd_dispatch

// ==== hw/pmd_fifo.sv ====
// Request FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module pmd_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q];

    // Storage writes; no reset is needed since the count guards reads.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= AW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= AW'(rd_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= (AW+1)'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= (AW+1)'(cnt_q - 1'b1);
            end
        end
    end
endmodule : pmd_fifo

// ==== hw/pmd_pkg.sv ====
// Shared constants and carrier types for the programmable machine dispatch block.
package pmd_pkg;

    // Pattern RAM geometry and field positions.
    localparam int unsigned RAM_DEPTH   = 64;
    localparam int unsigned RAM_AW      = 6;
    localparam int unsigned RAM_DW      = 32;
    localparam int unsigned BIT_LAST    = 0;
    localparam int unsigned BIT_XFER_ACK = 1;
    localparam int unsigned BIT_EXEN    = 25;
    localparam int unsigned AMX_LO      = 26;
    localparam int unsigned AMX_HI      = 27;

    // Pattern start words.
    localparam logic [5:0] SINGLE_READ_PATTERN  = 6'h00;
    localparam logic [5:0] BURST_READ_PATTERN   = 6'h08;
    localparam logic [5:0] SINGLE_WRITE_PATTERN = 6'h18;
    localparam logic [5:0] BURST_WRITE_PATTERN  = 6'h20;
    localparam logic [5:0] REFRESH_PATTERN      = 6'h30;
    localparam logic [5:0] EXCEPTION_PATTERN    = 6'h3C;

    // Machine opcodes.
    localparam logic [1:0] OP_NORMAL = 2'h0;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_RUN    = 2'h3;

    // Transfer shape: beats of a burst on each port size.
    localparam logic [5:0] BURST_ACKS_32 = 6'h08;
    localparam logic [5:0] BURST_ACKS_8  = 6'h20;
    localparam logic [5:0] SINGLE_ACKS   = 6'h01;

    // Idle local bus clock cycles between machine transactions.
    localparam logic [1:0] IDLE_GAP = 2'h2;

    // Request FIFO shape.
    localparam int unsigned FIFO_DEPTH = 16;

    // Machine index of the refresh executor.
    localparam int unsigned MACH_A = 0;
    localparam int unsigned N_MACH = 3;

    // One queued access request.
    typedef struct packed {
        logic       write;
        logic       burst;
        logic       fits;
        logic [1:0] machine;
    } pmd_req_t;

    localparam int unsigned REQ_W = 5;

    // Per-machine mode fields.
    typedef struct packed {
        logic [1:0] machine_opcode;
        logic [5:0] ram_word_pointer;
        logic       refresh_enable;
    } pmd_mode_t;

endpackage : pmd_pkg

// ==== hw/pmd_sync.sv ====
// Two-flop synchroniser with edge detection on the second stage output.
`timescale 1ns/10ps
module pmd_sync (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_n,
    // Asynchronous level in.
    input  wire logic async_in,
    // Synchronised level and its rising edge.
    output logic      sync_out,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // The first stage feeds only the second, so metastability never spreads.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sync_out = sync_q;
    assign rise     = sync_q && !prev_q;
endmodule : pmd_sync

// ==== tb/pmd_bus_partner.sv ====
// Far-side model: the free-running local bus clock.
`timescale 1ns/10ps
module pmd_bus_partner (
    // Bus clock.
    output logic local_bus_clock
);
    // Free-running clock, half period 80 ns or eight mclk periods, so its phase to mclk and the sync delay stay fixed.
    initial begin
        local_bus_clock = 1'b0;
        #37;
        forever #80 local_bus_clock = ~local_bus_clock;
    end
endmodule : pmd_bus_partner

// ==== tb/pmd_checker.sv ====
// Port checker for the dispatch block.
`timescale 1ns/10ps
module pmd_checker (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        rst_n,
    // Watched outputs.
    input wire logic        busy,
    input wire logic [31:0] ram_word,
    input wire logic        ram_word_valid,
    input wire logic [2:0]  chip_sel,
    input wire logic        xfer_start,
    input wire logic        xfer_ack,
    input wire logic        address_latch_enable,
    input wire logic        muxed_bus_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // A word that closes a pattern.
    sequence s_last;
        ram_word_valid && ram_word[0];
    endsequence
    // Eight quiet cycles; four of them span two bus clocks of 16 mclk each.
    sequence s_quiet;
        (!ram_word_valid)[*8];
    endsequence
    // The gap after a pattern end.
    sequence s_gap;
        s_quiet ##1 s_quiet ##1 s_quiet ##1 s_quiet;
    endsequence
    a_gap_after_last: assert property (s_last |=> s_gap) else $error("word inside gap");
    a_start_pulse: assert property (xfer_start |=> !xfer_start) else $error("long start");
    a_ack_pulse: assert property (xfer_ack |=> !xfer_ack) else $error("long ack");
    a_ale_pulse: assert property (address_latch_enable |=> !address_latch_enable) else $error("long ale");
    a_oe_with_ale: assert property (muxed_bus_oe |-> address_latch_enable) else $error("bus driven");
    a_start_busy: assert property (xfer_start |-> busy) else $error("start while idle");
    a_cs_busy: assert property ((|chip_sel) |-> busy) else $error("select while idle");
    a_idle_word: assert property ((!busy)[*2] |-> !ram_word_valid && ram_word == 32'h0) else $error("idle word");
endmodule : pmd_checker

bind pmd_dispatch pmd_checker i_pmd_checker (.mclk, .rst_n, .busy, .ram_word, .ram_word_valid, .chip_sel,
    .xfer_start, .xfer_ack, .address_latch_enable, .muxed_bus_oe);

// ==== tb/pmd_dispatch_tb_top.sv ====
// Self-checking bench for the dispatch block.
`timescale 1ns/10ps
module pmd_dispatch_tb_top;
    logic mclk, rst_n, lbclk, req_valid, port_8bit, bus_timeout, pdr_wr, busy, mon_en, req_ready;
    logic [2:0] burst_inhibit, chip_sel;
    logic [5:0] ptr_a, ptr_b, ptr_c;
    logic [7:0] refresh_period_reg;
    logic [31:0] pdr_wdata, pattern_data_reg, ram_word, words [5], exp_q [$];
    logic [5:0] starts [5] = '{6'h00, 6'h08, 6'h18, 6'h20, 6'h30};
    logic ram_word_valid;
    pmd_pkg::pmd_req_t req;
    pmd_pkg::pmd_mode_t mode_a, mode_b, mode_c;
    int n_fail, comparisons;

    pmd_bus_partner i_pmd_bus_partner (.local_bus_clock(lbclk));
    pmd_dispatch i_pmd_dispatch (.mclk, .rst_n, .local_bus_clock(lbclk), .req_valid, .req_ready, .req,
        .mode_a, .mode_b, .mode_c, .port_8bit, .burst_inhibit, .refresh_period_reg, .bus_timeout, .pdr_wr,
        .pdr_wdata, .pattern_data_reg, .ptr_a, .ptr_b, .ptr_c, .busy, .ram_word, .ram_word_valid,
        .chip_sel, .xfer_start(), .xfer_ack(), .address_latch_enable(), .muxed_bus_oe());

    task automatic stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic send(input logic w, input logic b);
        req_valid <= 1'b1;
        req <= '{write: w, burst: b, fits: 1'b1, machine: 2'h0};
        @(posedge mclk);
        req_valid <= 1'b0;
        @(posedge mclk);
    endtask : send
    // Opcode goes through normal first; the pointer is polled before moving on.
    task automatic dummy(input logic [1:0] op, input logic [5:0] a);
        mode_a <= '{machine_opcode: pmd_pkg::OP_NORMAL, ram_word_pointer: a, refresh_enable: 1'b0};
        repeat (3) @(posedge mclk);
        mode_a.machine_opcode <= op;
        repeat (2) @(posedge mclk);
        send(op == pmd_pkg::OP_WRITE, 1'b0);
        for (int k = 0; k < 2000 && ptr_a !== a + 6'h01; k++) @(posedge mclk);
        chk("word pointer", {26'h0, a + 6'h01}, {26'h0, ptr_a});
        if (ptr_a !== a + 6'h01) stop_test();
    endtask : dummy
    // Waits out all noted patterns, then the two-cycle bus gap.
    task automatic drain;
        for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge mclk);
        chk("patterns left", 32'h0, exp_q.size());
        if (exp_q.size() != 0) stop_test();
        repeat (40) @(posedge mclk);
        chk("idle outputs", 32'h1, {18'h0, ptr_b, ptr_c, busy, req_ready});
    endtask : drain

    // Clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Each executed word is matched against the oldest noted start word.
    always @(posedge mclk) begin
        if (mon_en && ram_word_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("extra pattern", 32'h0, 32'h1);
            else chk("pattern word", exp_q.pop_front(), ram_word);
        end
    end
    // Main sequence.
    initial begin
        {rst_n, req_valid, port_8bit, bus_timeout, pdr_wr, mon_en, burst_inhibit} = '0;
        {refresh_period_reg, pdr_wdata, req, mode_a, mode_b, mode_c} = '0;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(32'h42A3));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // One-word patterns hold ack and end together, exception enable clear.
        foreach (starts[i]) begin
            words[i] = ($urandom() & 32'hFDFF_FFFC) | 32'h0000_0003;
            pdr_wr <= 1'b1;
            pdr_wdata <= words[i];
            @(posedge mclk);
            pdr_wr <= 1'b0;
            dummy(pmd_pkg::OP_WRITE, starts[i]);
        end
        for (int i = 3; i >= 0; i--) begin
            dummy(pmd_pkg::OP_READ, starts[i]);
            chk("pattern data", words[i], pattern_data_reg);
        end
        // The mode is set only after the RAM is loaded.
        mode_a <= '0;
        mon_en <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(words[i]);
            send(i[1], i[0]);
        end
        drain();
        burst_inhibit <= 3'h1;
        exp_q.push_back(words[0]);
        send(1'b0, 1'b1);
        drain();
        mode_a <= '{machine_opcode: pmd_pkg::OP_RUN, ram_word_pointer: 6'h18, refresh_enable: 1'b0};
        repeat (3) @(posedge mclk);
        exp_q.push_back(words[2]);
        send(1'b1, 1'b0);
        drain();
        mode_a <= '{machine_opcode: pmd_pkg::OP_NORMAL, ram_word_pointer: 6'h00, refresh_enable: 1'b1};
        mode_b.refresh_enable <= 1'b1;
        exp_q.push_back(words[4]);
        refresh_period_reg <= 8'h03;
        for (int k = 0; k < 2000 && chip_sel === 3'h0; k++) @(posedge mclk);
        refresh_period_reg <= 8'h00;
        chk("refresh selects", 32'h3, {29'h0, chip_sel});
        drain();
        stop_test();
    end
endmodule : pmd_dispatch_tb_top
